/* bench/adcc_conv_model.sv */
// adcc_conv_model: comparator stand-in for the successive-approximation converter
// assumes the bench drives the analog level; the design samples comp_in through its synchroniser
`timescale 1ns/1ns
`default_nettype none
module adcc_conv_model (
	// clock
	input  wire logic        clk_sys,
	// analog level seen at the selected input
	input  wire logic [11:0] level,
	// converter pins
	input  wire logic [11:0] sar_trial,
	input  wire logic        sample_hold,
	output logic             comp_in
);
	logic chatter_q = 1'b0;

	// comparator output is meaningless unless the input is held
	always_ff @(posedge clk_sys) begin
		chatter_q <= ~chatter_q;
	end

	assign comp_in = sample_hold ? (level >= sar_trial) : chatter_q;
endmodule : adcc_conv_model
`default_nettype wire

/* bench/testbench.sv */
// testbench: self-checking bench for adcc_ctrl driven over APB
// assumes adcc_conv_model answers trial words from a bench-set level
`timescale 1ns/1ns
`default_nettype none
module testbench import adcc_pkg::*;;
	typedef struct {logic rd; logic err; logic [7:0] dat;} adcc_note_s;

	logic              clk_sys   = 1'b0;
	logic              rst_n     = 1'b0;
	logic [ADDR_W-1:0] paddr     = '0;
	logic              psel      = 1'b0;
	logic              penable   = 1'b0;
	logic              pwrite    = 1'b0;
	logic [31:0]       pwdata    = '0;
	logic              diff_link = 1'b0;
	logic [11:0]       level     = '0;
	wire  [31:0]       prdata;
	wire               pready;
	wire               pslverr;
	wire               comp_in;
	wire  [11:0]       sar_trial;
	wire               sample_hold;
	wire  [3:0]        mux_addr;
	wire  [3:0]        gain_sel;
	wire               conv_busy;
	adcc_note_s        notes[$];
	adcc_note_s        n_mon;
	int                bad_count   = 0;
	int                checks_done = 0;

	always #5 clk_sys = ~clk_sys;

	adcc_ctrl adcc_ctrl_i (
		.clk_sys(clk_sys), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.comp_in(comp_in), .diff_link(diff_link), .sar_trial(sar_trial),
		.sample_hold(sample_hold), .mux_addr(mux_addr), .gain_sel(gain_sel), .conv_busy(conv_busy)
	);

	adcc_conv_model adcc_conv_model_i (
		.clk_sys(clk_sys), .level(level), .sar_trial(sar_trial),
		.sample_hold(sample_hold), .comp_in(comp_in)
	);

	task automatic check_bus(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : check_bus

	task automatic check_pin(input string nm, input logic [11:0] e, input logic [11:0] g);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : check_pin

	task automatic complete_run();
		$display("checks %0d errors %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : complete_run

	// one apb transfer; the expected answer is queued first
	task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d, input logic e);
		adcc_note_s n;
		int         t;
		n = '{rd: !w, err: e, dat: d};
		notes.push_back(n);
		@(posedge clk_sys);
		paddr  <= a;
		pwrite <= w;
		pwdata <= {24'($urandom()), d};
		psel   <= 1'b1;
		@(posedge clk_sys);
		penable <= 1'b1;
		t = 0;
		do begin
			@(posedge clk_sys);
			t++;
		end while (pready !== 1'b1 && t < 50);
		psel    <= 1'b0;
		penable <= 1'b0;
		if (t == 50) begin
			check_pin("pready wait", 12'h1, 12'h0);
		end
	endtask : apb

	task automatic wait_busy(input logic lvl, input int lim, output int cyc);
		cyc = 0;
		while (conv_busy !== lvl && cyc < lim) begin
			@(posedge clk_sys);
			cyc++;
		end
	endtask : wait_busy

	// answer watcher
	always @(posedge clk_sys) begin
		if (pready === 1'b1) begin
			if (notes.size() == 0) begin
				check_pin("stray pready", 12'h0, 12'h1);
			end else begin
				n_mon = notes.pop_front();
				check_bus("pslverr", {31'h0, n_mon.err}, {31'h0, pslverr});
				if (n_mon.rd) begin
					check_bus("prdata", {24'h0, n_mon.dat}, prdata);
				end
			end
		end
	end

	initial begin
		repeat (60000) @(posedge clk_sys);
		bad_count++;
		complete_run();
	end

	initial begin
		int          c;
		int          t_exp;
		logic [3:0]  ch;
		logic [3:0]  gn;
		logic [3:0]  gx;
		logic [3:0]  mx;
		logic [7:0]  md;
		logic [11:0] res;
		c = $urandom(32'h8F821648);
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		check_pin("conv_busy", 12'h0, {11'h0, conv_busy});
		check_pin("gain_sel", 12'h0, {8'h0, gain_sel});
		apb(12'h008, 1'b1, 8'h00, 1'b1);
		apb(12'h00C, 1'b0, 8'h00, 1'b1);
		apb(12'h004, 1'b1, 8'h31, 1'b0);
		apb(12'h00C, 1'b1, 8'h01, 1'b1);
		apb(12'h004, 1'b1, GROUP_DEFAULT, 1'b0);
		apb(12'h020, 1'b0, 8'h00, 1'b1);
		apb(12'h009, 1'b0, 8'h00, 1'b1);
		apb(12'h00C, 1'b0, MODE_RST, 1'b0);
		for (int k = 0; k < 3; k++) begin
			diff_link <= (k == 2);
			ch = 4'($urandom());
			gn = (k == 0) ? 4'hF : 4'($urandom() % 11);
			md = {2'h0, 2'(k), 1'(k != 1), 1'(k == 1), 1'(k != 1), 1'(k != 0)};
			apb(12'h00C, 1'b1, md, 1'b0);
			apb(12'h00C, 1'b0, md, 1'b0);
			apb(12'h008, 1'b1, {gn, ch}, 1'b0);
			repeat (2) @(posedge clk_sys);
			gx = (gn > GAIN_MAX) ? GAIN_MAX : gn;
			mx = (k == 2) ? {1'b0, ch[2:0]} : ch;
			check_pin("gain_sel", {8'h0, gx}, {8'h0, gain_sel});
			check_pin("mux_addr", {8'h0, mx}, {8'h0, mux_addr});
			level <= 12'($urandom());
			apb(12'h010, 1'b1, 8'h00, 1'b0);
			wait_busy(1'b1, 8, c);
			check_pin("busy start", 12'h1, {11'h0, conv_busy});
			t_exp = (k == 1) ? SETTLE_CYC + 8 * BIT_STD_CYC : SETTLE_SH_CYC + ((k != 0) ? 8 : RES_BITS) * BIT_SH_CYC;
			wait_busy(1'b0, 30000, c);
			check_pin("conv time", 12'h1, {11'h0, 1'(c > t_exp - 10 && c < t_exp + 30)});
			res = (k != 0) ? {level[11:4], 4'h0} : level;
			res[11] = (k == 2) ? ~res[11] : res[11];
			apb(12'h008, 1'b0, {3'h0, 1'(k == 2), 4'h5}, 1'b0);
			apb(12'h010, 1'b0, res[7:0], 1'b0);
			apb(12'h014, 1'b0, {mx, res[11:8]}, 1'b0);
			apb(12'h018, 1'b0, res[7:0], 1'b0);
			apb(12'h01C, 1'b0, {mx, res[11:8]}, 1'b0);
			mx = (k == 1) ? mx + 4'h1 : mx;
			check_pin("scan step", {8'h0, mx}, {8'h0, mux_addr});
		end
		apb(12'h010, 1'b0, 8'h00, 1'b0);
		apb(12'h014, 1'b0, 8'h00, 1'b0);
		apb(12'h008, 1'b0, 8'h11, 1'b0);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		apb(12'h00C, 1'b0, 8'h00, 1'b1);
		check_pin("gain_sel", 12'h0, {8'h0, gain_sel});
		complete_run();
	end
endmodule : testbench
`default_nettype wire

/* common/adcc_pkg.sv */
// adcc_pkg: constants for the converter board control logic
// assumes a 100 MHz system clock and an APB register port
package adcc_pkg;
	// io command codes; the APB byte address is the code times four
	localparam logic [2:0] CMD_GROUP     = 3'h1;
	localparam logic [2:0] CMD_GAIN_CHAN = 3'h2;
	localparam logic [2:0] CMD_MODE      = 3'h3;
	localparam logic [2:0] CMD_START     = 3'h4;
	localparam logic [2:0] CMD_FIFO_HI   = 3'h5;
	localparam logic [2:0] CMD_LAST_LO   = 3'h6;
	localparam logic [2:0] CMD_LAST_HI   = 3'h7;
	localparam int         ADDR_W        = 12;
	localparam int         CMD_LSB       = 2;
	// gain/channel byte
	localparam int         GC_CHAN_LSB   = 0;
	localparam int         GC_GAIN_LSB   = 4;
	localparam logic [3:0] GAIN_MAX      = 4'hA;
	// mode byte
	localparam int         MODE_RES8     = 0;
	localparam int         MODE_SHORT    = 1;
	localparam int         MODE_SCAN     = 2;
	localparam int         MODE_SDLY     = 3;
	localparam int         MODE_CODE_LSB = 4;
	localparam logic [7:0] MODE_RST      = 8'h00;
	localparam logic [1:0] CODE_UNSIGNED = 2'h0;
	localparam logic [1:0] CODE_OFFSET   = 2'h1;
	localparam logic [1:0] CODE_TWOS     = 2'h2;
	// status byte
	localparam int         STAT_DONE     = 0;
	localparam int         STAT_BUSY     = 1;
	localparam int         STAT_NEMPTY   = 2;
	localparam int         STAT_FULL     = 3;
	localparam int         STAT_DIFF     = 4;
	// board group
	localparam logic [7:0] GROUP_DEFAULT = 8'h30;
	localparam logic [7:0] GROUP_RST     = 8'h00;
	// timing
	localparam int         CLK_NS        = 10;
	localparam int         SETTLE_NS     = 5000;
	localparam int         SETTLE_SH_NS  = 1000;
	localparam int         CONV_STD_NS   = 275000;
	localparam int         CONV_SH_NS    = 105000;
	localparam int         RES_BITS      = 12;
	localparam int         SETTLE_CYC    = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int         SETTLE_SH_CYC = (SETTLE_SH_NS + CLK_NS - 1) / CLK_NS;
	localparam int         BIT_STD_CYC   = CONV_STD_NS / (RES_BITS * CLK_NS);
	localparam int         BIT_SH_CYC    = CONV_SH_NS / (RES_BITS * CLK_NS);
	localparam int         CNT_W         = 12;
	localparam int         FIFO_W        = 16;
	localparam int         FIFO_DEPTH    = 16;
endpackage : adcc_pkg

/* design/adcc_ctrl.sv */
// adcc_ctrl: control logic of a 12-bit successive-approximation board
// assumes APB master on clk_sys; comparator and link pins are asynchronous
// Notes on behaviour
// - sequence 12-bit conversion, return full result
// - 8-bit resolution or short-cycle faster conversion
// - settling delay counter before each conversion
// - gain code selects one of eleven gains
// - one byte sets gain and channel
// - 16 single-ended or 8 differential channels
// - scanned channel stepping or fixed channel
// - gain, channel, resolution, mode registers retained
// - board select first, then command routing
// - result as unsigned, offset or two's complement
// - board answers group 30 by default
// - decode three io command lines
// - direction low is host output
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ns
`default_nettype none
module adcc_ctrl
	import adcc_pkg::*;
#(
	parameter logic [7:0] GROUP_SEL = GROUP_DEFAULT
) (
	// clock and reset
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	// apb slave
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// converter pins
	input  wire logic              comp_in,
	input  wire logic              diff_link,
	output logic [RES_BITS-1:0]    sar_trial,
	output logic                   sample_hold,
	output logic [3:0]             mux_addr,
	output logic [3:0]             gain_sel,
	output logic                   conv_busy
);
	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0001,
		ST_SETTLE = 4'b0010,
		ST_TRIAL  = 4'b0100,
		ST_STORE  = 4'b1000
	} adcc_state_e;

	function automatic logic [3:0] adcc_gain_clamp(input logic [3:0] g);
		adcc_gain_clamp = (g > GAIN_MAX) ? GAIN_MAX : g;
	endfunction : adcc_gain_clamp

	// pin synchronisers, three stages
	logic [2:0] sync_q [2];
	logic [1:0] pin_q;
	wire  [1:0] pin_raw = {diff_link, comp_in};
	for (genvar i = 0; i < 2; i++) begin : g_sync
		always_ff @(posedge clk_sys or negedge rst_n) begin
			if (!rst_n) begin
				sync_q[i] <= 3'h0;
				pin_q[i]  <= 1'b0;
			end else begin
				sync_q[i] <= {sync_q[i][1:0], pin_raw[i]};
				if (sync_q[i][1] == sync_q[i][2]) pin_q[i] <= sync_q[i][2];
			end
		end
	end
	wire comp_s = pin_q[0];
	wire diff_s = pin_q[1];

	// bus decode
	logic                pready_q;
	logic                pslverr_q;
	logic [31:0]         prdata_q;
	logic [7:0]          group_q;
	logic [7:0]          mode_q;
	logic [3:0]          gain_q;
	logic [3:0]          chan_q;
	logic                start_q;
	logic                done_q;
	logic [RES_BITS-1:0] last_q;
	logic [3:0]          last_chan_q;

	wire       io_command_bit0      = paddr[CMD_LSB];
	wire       io_command_bit1      = paddr[CMD_LSB+1];
	wire       io_command_bit2      = paddr[CMD_LSB+2];
	wire [2:0] io_cmd               = {io_command_bit2, io_command_bit1, io_command_bit0};
	wire       transfer_direction_n = ~pwrite;
	wire       addr_ok              = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:5] == '0) && (io_cmd != 3'h0);
	wire       board_sel            = group_q == GROUP_SEL;
	wire       acc_phase            = psel & penable & ~pready_q;
	wire       done_xfer            = psel & penable & pready_q;
	wire       host_out             = done_xfer & ~transfer_direction_n;
	wire       host_in              = done_xfer & transfer_direction_n;
	wire       wr_group             = host_out & addr_ok & (io_cmd == CMD_GROUP);
	wire       cmd_hit              = addr_ok & board_sel & (io_cmd != CMD_GROUP);
	wire       wr_gain_chan         = host_out & cmd_hit & (io_cmd == CMD_GAIN_CHAN);
	wire       wr_mode              = host_out & cmd_hit & (io_cmd == CMD_MODE);
	wire       wr_start             = host_out & cmd_hit & (io_cmd == CMD_START);
	wire       err_now              = ~addr_ok | (~board_sel & (io_cmd != CMD_GROUP));

	// mode fields
	wire       res8      = mode_q[MODE_RES8];
	wire       short_cyc = mode_q[MODE_SHORT];
	wire       scan      = mode_q[MODE_SCAN];
	wire       sdly      = mode_q[MODE_SDLY];
	wire [1:0] code_sel  = mode_q[MODE_CODE_LSB +: 2];

	// result fifo
	logic                fifo_in_ready;
	logic                fifo_out_valid;
	logic [FIFO_W-1:0]   fifo_out_data;
	logic [RES_BITS-1:0] sar_q;
	adcc_state_e         state_q;
	wire                 fifo_pop = host_in & cmd_hit & (io_cmd == CMD_FIFO_HI) & fifo_out_valid;
	wire                 storing  = state_q == ST_STORE;
	wire [RES_BITS-1:0]  coded    = (code_sel == CODE_TWOS) ? (sar_q ^ {1'b1, {(RES_BITS-1){1'b0}}}) : sar_q;

	adcc_fifo #(
		.W     (FIFO_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.in_valid  (storing),
		.in_ready  (fifo_in_ready),
		.in_data   ({chan_q, coded}),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_out_data)
	);

	// read data
	// empty buffer reads zero, never a stale or unwritten slot
	wire [FIFO_W-1:0]   head_word = fifo_out_valid ? fifo_out_data : '0;
	wire [RES_BITS-1:0] head_res = head_word[RES_BITS-1:0];
	wire [7:0] status = {3'h0, diff_s, ~fifo_in_ready, fifo_out_valid, state_q != ST_IDLE, done_q};
	logic [7:0] rd_byte;
	always_comb begin
		rd_byte = 8'h00;
		if (cmd_hit) begin
			unique case (io_cmd)
				CMD_GAIN_CHAN: rd_byte = status;
				CMD_MODE:      rd_byte = mode_q;
				CMD_START:     rd_byte = head_res[7:0];
				CMD_FIFO_HI:   rd_byte = {head_word[FIFO_W-1 -: 4], head_res[11:8]};
				CMD_LAST_LO:   rd_byte = last_q[7:0];
				CMD_LAST_HI:   rd_byte = {last_chan_q, last_q[11:8]};
				default:       rd_byte = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0;
		end else begin
			pready_q  <= acc_phase;
			pslverr_q <= acc_phase & err_now;
			prdata_q  <= (acc_phase & transfer_direction_n) ? {24'h0, rd_byte} : 32'h0;
		end
	end

	// configuration registers
	wire [3:0] gain_wr = adcc_gain_clamp(pwdata[GC_GAIN_LSB +: 4]);
	wire [3:0] chan_wr = pwdata[GC_CHAN_LSB +: 4];
	wire [3:0] chan_lim = diff_s ? 4'h7 : 4'hF;
	wire [3:0] chan_nxt = (chan_q >= chan_lim) ? 4'h0 : chan_q + 4'h1;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			group_q <= GROUP_RST;
			mode_q  <= MODE_RST;
			gain_q  <= 4'h0;
			chan_q  <= 4'h0;
		end else begin
			if (wr_group) group_q <= pwdata[7:0];
			if (wr_mode) mode_q <= pwdata[7:0];
			if (wr_gain_chan) begin
				gain_q <= gain_wr;
				chan_q <= chan_wr & chan_lim;
			end else if (storing && scan) begin
				chan_q <= chan_nxt;
			end else if (diff_s) begin
				chan_q <= chan_q & 4'h7;
			end
		end
	end

	// conversion sequencer
	logic [CNT_W-1:0]       cnt_q;
	logic [3:0]             bit_q;
	wire  [CNT_W-1:0]       settle_len = sdly ? CNT_W'(SETTLE_SH_CYC - 1) : CNT_W'(SETTLE_CYC - 1);
	wire  [CNT_W-1:0]       bit_len    = short_cyc ? CNT_W'(BIT_SH_CYC - 1) : CNT_W'(BIT_STD_CYC - 1);
	wire  [3:0]             last_bit   = res8 ? 4'(RES_BITS - 8) : 4'h0;
	wire  [RES_BITS-1:0]    bit_mask   = RES_BITS'(1) << bit_q;
	wire                    cnt_end    = cnt_q == '0;
	wire                    go         = start_q & fifo_in_ready;
	wire  [RES_BITS-1:0]    sar_keep   = comp_s ? sar_q : (sar_q & ~bit_mask);
	adcc_state_e            state_d;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE:   if (go) state_d = ST_SETTLE;
			ST_SETTLE: if (cnt_end) state_d = ST_TRIAL;
			ST_TRIAL:  if (cnt_end && bit_q == last_bit) state_d = ST_STORE;
			ST_STORE:  state_d = ST_IDLE;
			default:   state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			cnt_q   <= '0;
			bit_q   <= 4'h0;
			sar_q   <= '0;
		end else begin
			state_q <= state_d;
			if (state_q == ST_IDLE) begin
				cnt_q <= settle_len;
				bit_q <= 4'(RES_BITS - 1);
				sar_q <= '0;
			end else if (state_q == ST_SETTLE && cnt_end) begin
				cnt_q <= bit_len;
				sar_q <= RES_BITS'(1) << (RES_BITS - 1);
			end else if (state_q == ST_TRIAL && cnt_end) begin
				cnt_q <= bit_len;
				bit_q <= bit_q - 4'h1;
				sar_q <= (bit_q == last_bit) ? sar_keep : (sar_keep | (bit_mask >> 1));
			end else if (!cnt_end) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end

	// start request, result hold and complete flag
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			start_q     <= 1'b0;
			done_q      <= 1'b0;
			last_q      <= '0;
			last_chan_q <= 4'h0;
		end else begin
			start_q <= wr_start | (start_q & ~(state_q == ST_IDLE && go));
			if (storing) begin
				last_q      <= coded;
				last_chan_q <= chan_q;
				done_q      <= 1'b1;
			end else if (state_q == ST_IDLE && go) begin
				done_q <= 1'b0;
			end
		end
	end

	// pin outputs from flip-flops
	logic [RES_BITS-1:0] trial_q;
	logic                hold_q;
	logic [3:0]          mux_q;
	logic [3:0]          gsel_q;
	logic                busy_q;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			trial_q <= '0;
			hold_q  <= 1'b0;
			mux_q   <= 4'h0;
			gsel_q  <= 4'h0;
			busy_q  <= 1'b0;
		end else begin
			trial_q <= sar_q;
			hold_q  <= state_q == ST_TRIAL;
			mux_q   <= chan_q;
			gsel_q  <= gain_q;
			busy_q  <= state_q != ST_IDLE;
		end
	end

	assign prdata      = prdata_q;
	assign pready      = pready_q;
	assign pslverr     = pslverr_q;
	assign sar_trial   = trial_q;
	assign sample_hold = hold_q;
	assign mux_addr    = mux_q;
	assign gain_sel    = gsel_q;
	assign conv_busy   = busy_q;

	// checks
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	sequence s_settle_entry;
		state_q == ST_IDLE ##1 state_q == ST_SETTLE;
	endsequence
	sequence s_settle_hold;
		(state_q == ST_SETTLE) [*8];
	endsequence

	chk_pready_pulse: assert property (pready_q |=> !pready_q)
		else $error("pready stood two cycles");
	chk_group_latch: assert property (wr_group |=> group_q == $past(pwdata[7:0]))
		else $error("group byte not latched");
	chk_group_gate: assert property (host_out && !board_sel |=> $stable(gain_q) && $stable(mode_q))
		else $error("unselected board took a write");
	chk_gain_chan: assert property (wr_gain_chan && !diff_s |=> gain_q == $past(gain_wr) && chan_q == $past(chan_wr))
		else $error("gain and channel not both taken");
	chk_gain_range: assert property (gain_q <= GAIN_MAX)
		else $error("gain code above range");
	chk_diff_chan: assert property (diff_s |=> chan_q <= 4'h7)
		else $error("differential channel out of range");
	chk_settle_first: assert property (s_settle_entry |-> s_settle_hold)
		else $error("conversion began before settling");
	chk_trial_after: assert property ($rose(state_q == ST_TRIAL) |-> $past(state_q) == ST_SETTLE)
		else $error("trial without settle");
	chk_res8_low: assert property (storing && res8 |-> sar_q[3:0] == 4'h0)
		else $error("low bits set at 8-bit resolution");
	chk_result_hold: assert property (!storing |=> $stable(last_q))
		else $error("result changed without conversion");
	chk_done_flag: assert property (storing |=> done_q ##1 (done_q || state_q == ST_SETTLE))
		else $error("complete flag not raised");
	chk_scan_step: assert property (storing && scan && !wr_gain_chan && !diff_s |=> chan_q == $past(chan_nxt))
		else $error("scan did not step");
	chk_twos_code: assert property (storing && code_sel == CODE_TWOS |=> last_q[11] != $past(sar_q[11]))
		else $error("sign bit not converted");
	chk_err_answer: assert property (pslverr_q |-> pready_q)
		else $error("error flag without answer");
	chk_busy_track: assert property (state_q != ST_IDLE |=> busy_q)
		else $error("busy flag missed conversion");
	chk_store_room: assert property (storing |-> fifo_in_ready)
		else $error("result stored into full buffer");
	chk_empty_read: assert property (acc_phase && transfer_direction_n && cmd_hit && !fifo_out_valid
		&& io_cmd == CMD_FIFO_HI |=> prdata_q == 32'h0)
		else $error("empty buffer read not zero");
endmodule : adcc_ctrl
`default_nettype wire

/* design/adcc_fifo.sv */
// adcc_fifo: flip-flop result buffer, valid/ready on both sides
// assumes one clock; depth is a power of two
`timescale 1ns/1ns
`default_nettype none
module adcc_fifo #(
	parameter int W     = 16,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rst_n,
	// fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
		$error("adcc_fifo depth must be a power of two, at least 2");
	end

	logic [W-1:0] mem_q [DEPTH];
	logic [AW:0]  wr_q;
	logic [AW:0]  rd_q;
	wire          push = in_valid & in_ready;
	wire          pop  = out_valid & out_ready;

	assign in_ready  = (wr_q ^ rd_q) != {1'b1, {AW{1'b0}}};
	assign out_valid = wr_q != rd_q;
	assign out_data  = mem_q[rd_q[AW-1:0]];

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push) wr_q <= wr_q + 1'b1;
			if (pop) rd_q <= rd_q + 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (push) mem_q[wr_q[AW-1:0]] <= in_data;
	end
endmodule : adcc_fifo
`default_nettype wire
